// [dv/usdp_remote_model.sv]
// Remote serial device on channel 0: sends frames, decodes transmit frames
`timescale 1ns/1ns
module usdp_remote_model #(
    parameter BIT = 4
) (
    // Clock
    input wire clock_in,
    // Serial lines
    input wire tx_pin_in,
    output reg rx_pin_out
);
    // Decoded bytes and stop bit faults
    logic [7:0] got[$];
    integer bad_stop = 0;
    initial rx_pin_out = 1'b1;
    // Send one frame; bad pulls both stop bits low
    task automatic send(input logic [7:0] b, input logic bad);
        integer i;
        logic [10:0] f;
        f = {~bad, ~bad, b, 1'b0};
        for (i = 0; i < 11; i++) begin
            rx_pin_out = f[i];
            repeat (BIT) @(posedge clock_in);
            #1;
        end
        rx_pin_out = 1'b1;
        repeat (2 * BIT) @(posedge clock_in);
        #1;
    endtask
    // Decode transmit frames at mid bit, LSB first
    initial begin
        logic [7:0] d;
        integer i;
        forever begin
            @(negedge tx_pin_in);
            repeat (BIT / 2) @(posedge clock_in);
            for (i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clock_in);
                d[i] = tx_pin_in;
            end
            for (i = 0; i < 2; i++) begin
                repeat (BIT) @(posedge clock_in);
                if (!tx_pin_in) bad_stop++;
            end
            got.push_back(d);
        end
    end
endmodule

// [dv/usdp_top_checker.sv]
// Port checker of the two-channel serial block
`timescale 1ns/1ns
module usdp_top_checker (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Host port
    input wire [3:0] host_addr_in,
    input wire host_wr_in,
    input wire host_rd_in,
    input wire [7:0] host_wdata_in,
    input wire [7:0] host_rdata_out,
    // Serial pins and requests
    input wire [1:0] rx_pin_in,
    input wire [1:0] tx_pin_out,
    input wire [1:0] tx_pin_oe_out,
    input wire [1:0] irq_out
);
    // ----------------
    // Properties, bit time of 4 cycles as the bench sets it
    // ----------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // Status read on channel 0
    wire st_rd = host_rd_in && host_addr_in == 4'h0;
    a_float_high_zero: assert property (!tx_pin_oe_out[0] |-> tx_pin_out[0])
        else $error("ch0 tx low while undriven");
    a_float_high_one: assert property (!tx_pin_oe_out[1] |-> tx_pin_out[1])
        else $error("ch1 tx low while undriven");
    a_start_bit_len: assert property ($fell(tx_pin_out[0]) |-> (!tx_pin_out[0])[*4])
        else $error("start bit too short");
    a_bit_time_hold: assert property ($changed(tx_pin_out[0]) |=> $stable(tx_pin_out[0])[*3])
        else $error("tx bit shorter than a baud period");
    a_rdata_holds: assert property (!$past(host_rd_in) |-> $stable(host_rdata_out))
        else $error("read data moved without a read");
    a_idle_pin_high: assert property (st_rd |=> !host_rdata_out[1] || tx_pin_out[0])
        else $error("tx idle flag with low pin");
    a_idle_needs_empty: assert property (st_rd |=> host_rdata_out[1:0] != 2'b10)
        else $error("tx idle without tx empty");
    a_oe_after_write: assert property ($rose(tx_pin_oe_out[0]) |->
        $past(host_wr_in) || $past(host_wr_in, 2)) else $error("tx enabled without a write");
    // Main scenarios
    c_tx_frame: cover property ($fell(tx_pin_out[0]));
    c_rx_ready: cover property (st_rd ##1 host_rdata_out[2]);
    c_rx_request: cover property ($rose(irq_out[0]));
endmodule
bind usdp_top usdp_top_checker chk_u (.clock_in(clock_in), .rst_in(rst_in),
    .host_addr_in(host_addr_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
    .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out), .rx_pin_in(rx_pin_in),
    .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out), .irq_out(irq_out));

// [dv/usdp_top_test.sv]
// Self-checking bench of the two-channel serial block
`timescale 1ns/1ns
module usdp_top_test;
    // ----------------
    // Stimulus, design and far side
    // ----------------
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] host_addr_in = 4'h0;
    logic host_wr_in = 1'b0;
    logic host_rd_in = 1'b0;
    logic [7:0] host_wdata_in = 8'h00;
    wire rx0;
    wire [1:0] rx_pin_in = {1'b1, rx0};
    wire [7:0] host_rdata_out;
    wire [1:0] tx_pin_out;
    wire [1:0] irq_out;
    integer errors = 0;
    integer n_checks = 0;
    integer k;
    logic [7:0] v, b;
    logic [7:0] exp_q[$];
    // Clock of 20 ns period
    always #10 clock_in = ~clock_in;
    usdp_top dut_u (.clock_in(clock_in), .rst_in(rst_in), .host_addr_in(host_addr_in),
        .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
        .host_rdata_out(host_rdata_out), .rx_pin_in(rx_pin_in), .tx_pin_out(tx_pin_out),
        .tx_pin_oe_out(), .irq_out(irq_out));
    usdp_remote_model #(.BIT(4)) far_u (.clock_in(clock_in), .tx_pin_in(tx_pin_out[0]),
        .rx_pin_out(rx0));
    // ----------------
    // Tasks
    // ----------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One host access; read data lands in v
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1 host_addr_in = a;
        host_wdata_in = d;
        host_wr_in = w;
        host_rd_in = !w;
        @(posedge clock_in);
        #1 host_wr_in = 1'b0;
        host_rd_in = 1'b0;
        v = host_rdata_out;
    endtask
    task automatic rc(input logic [3:0] a, input string n, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(n, e, v);
    endtask
    // Read status until a masked bit is set, bounded
    task automatic poll(input logic [7:0] m);
        integer i;
        v = 8'h00;
        for (i = 0; i < 200 && (v & m) == 8'h00; i++) acc(1'b0, 4'h0, 8'h00);
        if ((v & m) == 8'h00) begin
            errors++;
            end_of_test;
        end
    endtask
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        v = $urandom(12);
        repeat (4) @(posedge clock_in);
        #1 rst_in = 1'b0;
        // Divisors on both channels, enables, receive request
        acc(1'b1, 4'h5, 8'h03);
        acc(1'b1, 4'hd, 8'h07);
        rc(4'h5, "divisor ch0", 8'h03);
        rc(4'hd, "divisor ch1", 8'h07);
        rc(4'h8, "status ch1", 8'h0b);
        acc(1'b1, 4'h1, 8'h80);
        acc(1'b1, 4'h2, 8'hc4);
        rc(4'h0, "status", 8'h0b);
        acc(1'b1, 4'h0, 8'hff);
        rc(4'h0, "status", 8'h0b);
        // Two bytes out, second queued behind the first
        b = $urandom;
        exp_q.push_back(b);
        acc(1'b1, 4'h3, b);
        poll(8'h01);
        b = $urandom;
        exp_q.push_back(b);
        acc(1'b1, 4'h3, b);
        rc(4'h0, "status", 8'h08);
        poll(8'h02);
        rc(4'h0, "status", 8'h0b);
        for (k = 0; k < 2; k++) chk("tx byte", exp_q.pop_front(), far_u.got.pop_front());
        // Four bytes fill the queue, a fifth overruns
        for (k = 0; k < 5; k++) begin
            b = $urandom;
            if (k < 4) exp_q.push_back(b);
            fork
                far_u.send(b, 1'b0);
                if (k == 0) begin
                    repeat (20) @(posedge clock_in);
                    rc(4'h0, "status", 8'h03);
                end
            join
        end
        rc(4'h0, "status", 8'h1f);
        chk("irq", 8'h01, {7'h00, irq_out[0]});
        for (k = 0; k < 4; k++) begin
            rc(4'h3, "rx byte", exp_q.pop_front());
            if (k == 0 || k == 2) rc(4'h0, "status", 8'h0f);
        end
        rc(4'h0, "status", 8'h0b);
        // Byte with low stop bits
        b = $urandom;
        far_u.send(b, 1'b1);
        rc(4'h0, "status", 8'h2f);
        rc(4'h3, "rx byte", b);
        rc(4'h0, "status", 8'h0b);
        chk("stop faults", 8'h00, 8'(far_u.bad_stop));
        end_of_test;
    end
endmodule

// [verilog/usdp_regs.vh]
// Register indices, field positions, reset values and codes of the serial block
`ifndef USDP_REGS_VH
`define USDP_REGS_VH

// ------------------------------------------------------------
// Register indices within one channel
// ------------------------------------------------------------
`define USDP_IDX_STATUS 3'h0
`define USDP_IDX_CTL1 3'h1
`define USDP_IDX_CTL2 3'h2
`define USDP_IDX_DATA 3'h3
`define USDP_IDX_BDH 3'h4
`define USDP_IDX_BDL 3'h5
`define USDP_IDX_FMC 3'h6
`define USDP_IDX_RXCNT 3'h7

// ------------------------------------------------------------
// Status bit positions
// ------------------------------------------------------------
`define USDP_SR_PERR 7
`define USDP_SR_NF 6
`define USDP_SR_FERR 5
`define USDP_SR_OERR 4
`define USDP_SR_RIDLE 3
`define USDP_SR_RXIF 2
`define USDP_SR_TIDLE 1
`define USDP_SR_TXIF 0
`define USDP_SR_RESET 8'h0b

// ------------------------------------------------------------
// Control one and control two bit positions
// ------------------------------------------------------------
`define USDP_C1_EN 7
`define USDP_C1_NINE 6
`define USDP_C1_PREN 5
`define USDP_C1_PRT_HI 4
`define USDP_C1_PRT_LO 3
`define USDP_C1_BRK 2
`define USDP_C1_RX8 1
`define USDP_C1_TX8 0
`define USDP_C2_TXEN 7
`define USDP_C2_RXEN 6
`define USDP_C2_STOPS 5
`define USDP_C2_RIE 2
`define USDP_C2_TIIE 1
`define USDP_C2_TEIE 0

// ------------------------------------------------------------
// Parity types, trigger codes, frame lengths
// ------------------------------------------------------------
`define USDP_PAR_EVEN 2'h0
`define USDP_PAR_ODD 2'h1
`define USDP_PAR_MARK 2'h2
`define USDP_PAR_SPACE 2'h3
`define USDP_TRG_ONE 2'h0
`define USDP_TRG_TWO 2'h1
`define USDP_FRAME_8 4'hb
`define USDP_FRAME_9 4'hc
`define USDP_CTL_RESET 8'h00

`endif

// [verilog/usdp_uart.v]
// Two-channel serial transceiver: receive queue, channel logic and top
`timescale 1ns/1ns
`include "usdp_regs.vh"

// ------------------------------------------------------------
// Queue of flip-flops with valid/ready on both sides
// ------------------------------------------------------------
module usdp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    input wire flush_in,
    // Fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out,
    output wire [AW:0] count_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    integer i;

    // Honest full and empty from the fill count
    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out = mem_q[rp_q];
    assign count_out = cnt_q;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Pointer and count update, flush wins
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else if (flush_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data_in;
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// One serial channel with its eight registers
// ------------------------------------------------------------
module usdp_channel #(
    parameter RX_DEPTH = 4,
    parameter RX_AW = 2
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Host access
    input wire [2:0] idx_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    // Serial pins and request
    input wire rx_pin_in,
    output reg tx_pin_out,
    output reg tx_oe_out,
    output reg irq_out
);
    localparam RX_IDLE = 1'b0;
    localparam RX_RUN = 1'b1;

    reg [7:0] ctl1_q, ctl2_q, bdh_q, bdl_q;
    reg [5:0] fmc_q;
    reg perr_q, nf_q, ferr_q, oerr_q, rxif_q, tidle_q, txif_q;
    reg [7:0] seen_q;
    reg [15:0] baud_q;
    reg [8:0] hold_q;
    reg hold_full_q;
    reg [11:0] tx_sh_q;
    reg [3:0] tx_left_q;
    reg rx_state_q;
    reg [2:0] rx_hist_q;
    reg [15:0] rx_cnt_q;
    reg [3:0] rx_idx_q;
    reg [8:0] rx_sh_q;
    reg rx_noise_q, rx_ferr_q;

    wire [15:0] divisor;
    wire en, nine, txen, rxen, brk, tick, rx_flush, stat_rd, data_rd, data_wr, data_acc;
    wire [RX_AW:0] rx_count;
    wire rx_ready, rx_valid, rx_push, rx_sample, rx_bit, rx_last, maj_noise;
    wire [8:0] rx_head, rx_word;
    wire [3:0] rx_nb;
    wire [RX_AW:0] trig;
    wire [7:0] status;
    wire par_err;
    wire [11:0] frame;

    // Parity of the word's low bits for the selected type
    function par_fn;
        input [8:0] d;
        input n9;
        input [1:0] typ;
        reg [7:0] low;
        begin
            low = n9 ? d[7:0] : {1'b0, d[6:0]};
            case (typ)
                `USDP_PAR_EVEN: par_fn = ^low;
                `USDP_PAR_ODD: par_fn = ~(^low);
                `USDP_PAR_MARK: par_fn = 1'b1;
                default: par_fn = 1'b0;
            endcase
        end
    endfunction

    // Control decode
    assign en = ctl1_q[`USDP_C1_EN];
    assign nine = ctl1_q[`USDP_C1_NINE];
    assign brk = ctl1_q[`USDP_C1_BRK];
    assign txen = ctl2_q[`USDP_C2_TXEN] & en;
    assign rxen = ctl2_q[`USDP_C2_RXEN] & en;
    assign divisor = {bdh_q, bdl_q};
    assign stat_rd = rd_in & (idx_in == `USDP_IDX_STATUS);
    assign data_rd = rd_in & (idx_in == `USDP_IDX_DATA);
    assign data_wr = wr_in & (idx_in == `USDP_IDX_DATA);
    assign data_acc = data_rd | data_wr;
    assign tick = (baud_q == 16'h0000);

    // Status image, read only to the host; receiver idle also while disabled
    assign status = {perr_q, nf_q, ferr_q, oerr_q, (rx_state_q == RX_IDLE),
        rxif_q, tidle_q, txif_q};

    // Receive queue ahead of the data register
    assign rx_flush = ~rxen;
    usdp_fifo #(.WIDTH(9), .DEPTH(RX_DEPTH), .AW(RX_AW)) u_rxq (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .flush_in(rx_flush),
        .in_valid_in(rx_push),
        .in_ready_out(rx_ready),
        .in_data_in(rx_word),
        .out_valid_out(rx_valid),
        .out_ready_in(data_rd),
        .out_data_out(rx_head),
        .count_out(rx_count)
    );

    // Host read mux; shift registers have no index
    always @* begin
        case (idx_in)
            `USDP_IDX_STATUS: rdata_out = status;
            `USDP_IDX_CTL1: rdata_out = {ctl1_q[7:2], rx_head[8], 1'b0};
            `USDP_IDX_CTL2: rdata_out = ctl2_q;
            `USDP_IDX_DATA: rdata_out = rx_valid ? rx_head[7:0] : 8'h00;
            `USDP_IDX_BDH: rdata_out = bdh_q;
            `USDP_IDX_BDL: rdata_out = bdl_q;
            `USDP_IDX_FMC: rdata_out = {2'h0, fmc_q};
            `USDP_IDX_RXCNT: rdata_out = {{(7-RX_AW){1'b0}}, rx_count};
            default: rdata_out = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Control registers; status has no write path
    // ------------------------------------------------------------
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctl1_q <= `USDP_CTL_RESET;
            ctl2_q <= `USDP_CTL_RESET;
            bdh_q <= `USDP_CTL_RESET;
            bdl_q <= `USDP_CTL_RESET;
            fmc_q <= 6'h00;
        end else begin
            if (wr_in) begin
                case (idx_in)
                    `USDP_IDX_CTL1: ctl1_q <= wdata_in;
                    `USDP_IDX_CTL2: ctl2_q <= wdata_in;
                    `USDP_IDX_BDH: bdh_q <= wdata_in;
                    `USDP_IDX_BDL: bdl_q <= wdata_in;
                    `USDP_IDX_FMC: fmc_q <= wdata_in[5:0];
                    default: ctl2_q <= ctl2_q;
                endcase
            end
            if (~en) begin
                // Disabled channel drops enables and break
                ctl2_q[`USDP_C2_TXEN] <= 1'b0;
                ctl2_q[`USDP_C2_RXEN] <= 1'b0;
                ctl1_q[`USDP_C1_BRK] <= 1'b0;
            end
        end
    end

    // Baud generator, period is divisor plus one cycles
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            baud_q <= 16'h0000;
        end else if (~en | tick) begin
            baud_q <= divisor;
        end else begin
            baud_q <= baud_q - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    assign frame = nine ?
        {2'b11, nine & ctl1_q[`USDP_C1_PREN] ?
            par_fn(hold_q, 1'b1, ctl1_q[`USDP_C1_PRT_HI:`USDP_C1_PRT_LO]) : hold_q[8],
            hold_q[7:0], 1'b0} :
        {3'b111, ctl1_q[`USDP_C1_PREN] ?
            par_fn(hold_q, 1'b0, ctl1_q[`USDP_C1_PRT_HI:`USDP_C1_PRT_LO]) : hold_q[7],
            hold_q[6:0], 1'b0};

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= 9'h000;
            hold_full_q <= 1'b0;
            tx_sh_q <= 12'hfff;
            tx_left_q <= 4'h0;
            tx_pin_out <= 1'b1;
            tx_oe_out <= 1'b0;
            txif_q <= 1'b1;
            tidle_q <= 1'b1;
        end else begin
            tx_oe_out <= txen;
            if (~txen) begin
                // Abort and reset the transmitter
                hold_full_q <= 1'b0;
                tx_left_q <= 4'h0;
                tx_pin_out <= 1'b1;
                txif_q <= 1'b1;
                tidle_q <= 1'b1;
            end else begin
                // Sequence read status then write data clears
                if (data_wr & seen_q[`USDP_SR_TXIF]) begin
                    txif_q <= 1'b0;
                end
                // A queued byte never leaves the idle flag up
                if (data_wr) begin
                    tidle_q <= 1'b0;
                end
                if (data_wr) begin
                    hold_q <= {ctl1_q[`USDP_C1_TX8], wdata_in};
                    hold_full_q <= 1'b1;
                end
                if (tick) begin
                    if (tx_left_q != 4'h0) begin
                        tx_pin_out <= tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                        tx_left_q <= tx_left_q - 4'h1;
                    end else if (hold_full_q) begin
                        // Start bit goes out at once
                        tx_pin_out <= frame[0];
                        tx_sh_q <= {1'b1, frame[11:1]};
                        tx_left_q <= (nine ? `USDP_FRAME_9 : `USDP_FRAME_8) - 4'h1;
                        hold_full_q <= data_wr;
                        txif_q <= 1'b1;
                    end else if (brk) begin
                        tx_pin_out <= 1'b0;
                    end else begin
                        tx_pin_out <= 1'b1;
                        tidle_q <= txif_q & ~data_wr;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    assign rx_nb = nine ? 4'h9 : 4'h8;
    assign rx_sample = (rx_state_q == RX_RUN) & (rx_cnt_q == 16'h0000);
    assign rx_bit = (rx_hist_q[0] & rx_hist_q[1]) | (rx_hist_q[1] & rx_hist_q[2]) |
        (rx_hist_q[0] & rx_hist_q[2]);
    assign maj_noise = ~(&rx_hist_q) & (|rx_hist_q);
    assign rx_last = rx_sample &
        (rx_idx_q == rx_nb + (ctl2_q[`USDP_C2_STOPS] ? 4'h2 : 4'h1));
    assign rx_word = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    assign par_err = ctl1_q[`USDP_C1_PREN] &
        ((nine ? rx_word[8] : rx_word[7]) !=
        par_fn(rx_word, nine, ctl1_q[`USDP_C1_PRT_HI:`USDP_C1_PRT_LO]));
    assign rx_push = rx_last & ~oerr_q;
    localparam [RX_AW:0] TRIG_LVL_ONE = 1;
    localparam [RX_AW:0] TRIG_LVL_TWO = 2;
    localparam [RX_AW:0] TRIG_LVL_FULL = RX_DEPTH;
    assign trig = (fmc_q[1:0] == `USDP_TRG_ONE) ? TRIG_LVL_ONE :
        (fmc_q[1:0] == `USDP_TRG_TWO) ? TRIG_LVL_TWO : TRIG_LVL_FULL;

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rx_state_q <= RX_IDLE;
            rx_hist_q <= 3'h7;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_noise_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else begin
            rx_hist_q <= {rx_hist_q[1:0], rx_pin_in};
            case (rx_state_q)
                RX_IDLE: begin
                    // Falling edge of idle-high line
                    if (rxen & rx_hist_q[1] & ~rx_hist_q[0]) begin
                        rx_state_q <= RX_RUN;
                        rx_cnt_q <= {1'b0, divisor[15:1]};
                        rx_idx_q <= 4'h0;
                        rx_noise_q <= 1'b0;
                        rx_ferr_q <= 1'b0;
                    end
                end
                RX_RUN: begin
                    if (~rxen) begin
                        rx_state_q <= RX_IDLE;
                    end else if (rx_sample) begin
                        rx_cnt_q <= divisor;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        rx_noise_q <= rx_noise_q | maj_noise;
                        if (rx_idx_q == 4'h0 && rx_bit) begin
                            rx_state_q <= RX_IDLE; // False start
                        end else if (rx_idx_q != 4'h0 && rx_idx_q <= rx_nb) begin
                            rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
                        end else if (rx_idx_q > rx_nb) begin
                            rx_ferr_q <= rx_ferr_q | ~rx_bit;
                        end
                        if (rx_last) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive flags and status-read tracking; set beats clear
    // ------------------------------------------------------------
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            perr_q <= 1'b0;
            nf_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            rxif_q <= 1'b0;
            seen_q <= 8'h00;
            irq_out <= 1'b0;
        end else if (~rxen) begin
            perr_q <= 1'b0;
            nf_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            rxif_q <= 1'b0;
            // Status record kept so transmit clears still work
            if (stat_rd) begin
                seen_q <= status;
            end else if (data_acc) begin
                seen_q <= 8'h00;
            end
            irq_out <= (txif_q & ctl2_q[`USDP_C2_TEIE]) | (tidle_q & ctl2_q[`USDP_C2_TIIE]);
        end else begin
            if (stat_rd) begin
                seen_q <= status;
            end else if (data_acc) begin
                seen_q <= 8'h00;
            end
            if (data_acc & seen_q[`USDP_SR_PERR]) perr_q <= 1'b0;
            if (data_acc & seen_q[`USDP_SR_NF]) nf_q <= 1'b0;
            if (data_acc & seen_q[`USDP_SR_FERR]) ferr_q <= 1'b0;
            if (data_acc & seen_q[`USDP_SR_OERR]) oerr_q <= 1'b0;
            if (data_rd & seen_q[`USDP_SR_RXIF] & (rx_count <= 1)) rxif_q <= 1'b0;
            if (rx_push & rx_ready) begin
                // Error flags land with the transfer
                if (par_err) perr_q <= 1'b1;
                if (rx_noise_q | maj_noise) nf_q <= 1'b1;
                if (rx_ferr_q | ~rx_bit) ferr_q <= 1'b1;
                if (rx_count + 1'b1 >= trig) rxif_q <= 1'b1;
            end
            if (rx_last & (~rx_ready | oerr_q)) begin
                oerr_q <= 1'b1;
            end
            irq_out <= (rxif_q & ctl2_q[`USDP_C2_RIE]) |
                (txif_q & ctl2_q[`USDP_C2_TEIE]) | (tidle_q & ctl2_q[`USDP_C2_TIIE]);
        end
    end
endmodule

// ------------------------------------------------------------
// Top: two independent channels sharing the host port
// ------------------------------------------------------------
module usdp_top #(
    parameter RX_DEPTH = 4,
    parameter RX_AW = 2
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Host register port
    input wire [3:0] host_addr_in,
    input wire host_wr_in,
    input wire host_rd_in,
    input wire [7:0] host_wdata_in,
    output reg [7:0] host_rdata_out,
    // Serial pins
    input wire [1:0] rx_pin_in,
    output wire [1:0] tx_pin_out,
    output wire [1:0] tx_pin_oe_out,
    // Requests
    output wire [1:0] irq_out
);
    wire [15:0] rd_all;

    // Two channels selected by the top address bit
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ch
            usdp_channel #(.RX_DEPTH(RX_DEPTH), .RX_AW(RX_AW)) u_ch (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .idx_in(host_addr_in[2:0]),
                .wr_in(host_wr_in & (host_addr_in[3] == g)),
                .rd_in(host_rd_in & (host_addr_in[3] == g)),
                .wdata_in(host_wdata_in),
                .rdata_out(rd_all[g*8 +: 8]),
                .rx_pin_in(rx_pin_in[g]),
                .tx_pin_out(tx_pin_out[g]),
                .tx_oe_out(tx_pin_oe_out[g]),
                .irq_out(irq_out[g])
            );
        end
    endgenerate
    // Registered read data, one cycle after the strobe
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            host_rdata_out <= 8'h00;
        end else if (host_rd_in) begin
            host_rdata_out <= host_addr_in[3] ? rd_all[15:8] : rd_all[7:0];
        end
    end
endmodule
